// ---- pkg/fpic_defines.svh ----
// Offsets, field positions, reset values and widths of the operand input control
`ifndef FPIC_DEFINES_SVH
`define FPIC_DEFINES_SVH
`define FPIC_WORD_W 32
`define FPIC_PAR_W 4
`define FPIC_ADDR_W 6
// Register byte offsets
`define FPIC_OFS_CTRL 6'h00
`define FPIC_OFS_STATUS 6'h04
`define FPIC_OFS_MASK 6'h08
`define FPIC_OFS_LEFT 6'h0C
`define FPIC_OFS_RIGHT 6'h10
`define FPIC_OFS_TEMP_LO 6'h14
`define FPIC_OFS_TEMP_HI 6'h18
`define FPIC_OFS_HOLD 6'h1C
// Control fields
`define FPIC_CTRL_BYTE_BIT 0
`define FPIC_CTRL_EDGE_BIT 1
`define FPIC_CTRL_SRC_LO 2
`define FPIC_CTRL_SRC_HI 3
`define FPIC_CTRL_PIPE_BIT 4
`define FPIC_CTRL_SUDDEN_BIT 5
`define FPIC_CTRL_SLAVE_BIT 6
`define FPIC_CTRL_W 7
`define FPIC_CTRL_RESET 7'h00
// Status and mask fields
`define FPIC_ST_PERR_A 0
`define FPIC_ST_PERR_B 1
`define FPIC_ST_CMP 2
`define FPIC_ST_W 3
`define FPIC_ST_RESET 3'h0
// Single format exponent field, used for the denormal test
`define FPIC_EXP_LO 23
`define FPIC_EXP_HI 30
`endif

// ---- pkg/fpic_pkg.sv ----
// Types shared by the operand input control block
`include "fpic_defines.svh"
package fpic_pkg;
   // Operand source selection
   typedef enum logic [1:0] {
      FPIC_SRC_A_B = 2'b00,
      FPIC_SRC_TEMP = 2'b01,
      FPIC_SRC_A_TLO = 2'b10,
      FPIC_SRC_THI_B = 2'b11
   } fpic_src_type;
   // Software control bits
   typedef struct packed {
      logic slave_mode;
      logic sudden_underflow;
      logic input_pipeline_select;
      fpic_src_type operand_source_select;
      logic temp_load_edge_select;
      logic parity_granularity_select;
   } fpic_ctrl_type;
   // Complete block state
   typedef struct packed {
      fpic_ctrl_type ctrl;
      logic [`FPIC_ST_W-1:0] status;
      logic [`FPIC_ST_W-1:0] mask;
      logic [63:0] temp_register;
      logic [63:0] temp_stage;
      logic temp_stage_valid;
      logic [31:0] left_input_latch;
      logic [31:0] right_input_latch;
      logic [31:0] holding_register;
      logic [3:0] result_bus_parity;
      logic result_drive;
      logic [1:0] hold_clk_sync;
      logic hold_clk_last;
      logic first_bus_parity_error;
      logic second_bus_parity_error;
      logic lockstep_compare_error;
      logic ack;
      logic [31:0] readdata;
   } fpic_state_type;
endpackage

// ---- verilog/fpic_input_ctrl.sv ----
// Operand input parity checking, source selection and register loading
//
// Contract
// - Byte mode: four parity bits, one per byte
// - Word mode: one parity bit per bus
// - Parity is even on every bus
// - First bus parity failure raises its error
// - Second bus parity failure raises its error
// - All registers except holding use master clock; here the holding register also runs on it and only samples its own clock
// - Holding register writes on its clock, enable low
// - Temp register loads on edge set by select
// - Source select picks A, B or temp
// - Left latch loads when enabled, not flowthrough
// - Right latch loads when enabled, not flowthrough
// - Underflow select low keeps denormals (gradual)
// - Results leave on a 32-bit two-way bus
// - Underflow select high flushes denormals to zero
// - Pipeline select high makes latches transparent
// - Bus data goes to temp or latch
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "fpic_defines.svh"
module fpic_input_ctrl import fpic_pkg::*; (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Avalon-MM register slave
   input wire logic [`FPIC_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Interrupt
   output logic irq_out,
   // Operand buses and their parity
   input wire logic [31:0] first_operand_bus_in,
   input wire logic [31:0] second_operand_bus_in,
   input wire logic [3:0] first_bus_parity_in,
   input wire logic [3:0] second_bus_parity_in,
   output logic first_bus_parity_error_out,
   output logic second_bus_parity_error_out,
   // Load controls
   input wire logic left_input_load_enable_in,
   input wire logic right_input_load_enable_in,
   input wire logic temp_register_load_in,
   // Operands presented to the datapath
   output logic [31:0] left_operand_out,
   output logic [31:0] right_operand_out,
   // Holding register
   input wire logic holding_register_clock_in,
   input wire logic holding_register_write_enable_n_in,
   input wire logic [31:0] result_data_in,
   input wire logic result_output_enable_n_in,
   // Two-way result bus and its parity
   input wire logic [31:0] result_bus_in,
   output logic [31:0] result_bus_out,
   output logic result_bus_oe_out,
   input wire logic [3:0] result_bus_parity_in,
   output logic [3:0] result_bus_parity_out,
   output logic result_bus_parity_oe_out,
   output logic lockstep_compare_error_out
);

   // ************************************************************
   // Functions
   // ************************************************************

   // Even parity check; byte mode checks each lane, word mode uses bit 0 only
   function automatic logic parity_fail(input logic [31:0] data, input logic [3:0] par,
                                        input logic byte_mode);
      logic fail;
      fail = 1'b0;
      if (byte_mode) begin
         for (int i = 0; i < 4; i++) begin
            fail = fail | (^{data[8*i +: 8], par[i]});
         end
      end else begin
         fail = ^{data, par[0]};
      end
      return fail;
   endfunction

   // Even parity generation at the same granularity as the checker
   function automatic logic [3:0] parity_gen(input logic [31:0] data, input logic byte_mode);
      logic [3:0] par;
      par = 4'h0;
      if (byte_mode) begin
         for (int i = 0; i < 4; i++) begin
            par[i] = ^data[8*i +: 8];
         end
      end else begin
         par[0] = ^data;
      end
      return par;
   endfunction

   // Denormal flush: zero exponent with nonzero fraction becomes signed zero
   function automatic logic [31:0] underflow(input logic [31:0] word, input logic sudden);
      logic [31:0] res;
      res = word;
      if (sudden && (word[`FPIC_EXP_HI:`FPIC_EXP_LO] == 8'h00)) begin
         res = {word[31], 31'h0000_0000};
      end
      return res;
   endfunction

   // Byte-enable merge of a write into a stored word
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = wdata[8*i +: 8];
         end
      end
      return res;
   endfunction

   // ************************************************************
   // State
   // ************************************************************

   fpic_state_type state_reg;
   fpic_state_type state_next;
   logic [31:0] left_source;
   logic [31:0] right_source;
   logic perr_a;
   logic perr_b;
   logic cmp_err;
   logic hold_edge;
   logic access;
   logic [31:0] ctrl_word;
   logic [31:0] wmerge;

   // Source multiplexers; the encoding is a fixed table of this block
   always_comb begin
      case (state_reg.ctrl.operand_source_select)
         FPIC_SRC_A_B: begin
            left_source = first_operand_bus_in;
            right_source = second_operand_bus_in;
         end
         FPIC_SRC_TEMP: begin
            left_source = state_reg.temp_register[63:32];
            right_source = state_reg.temp_register[31:0];
         end
         FPIC_SRC_A_TLO: begin
            left_source = first_operand_bus_in;
            right_source = state_reg.temp_register[31:0];
         end
         default: begin
            left_source = state_reg.temp_register[63:32];
            right_source = second_operand_bus_in;
         end
      endcase
   end

   // Event sources: parity on operand buses, mismatch on the result bus
   assign perr_a = parity_fail(first_operand_bus_in, first_bus_parity_in,
                               state_reg.ctrl.parity_granularity_select);
   assign perr_b = parity_fail(second_operand_bus_in, second_bus_parity_in,
                               state_reg.ctrl.parity_granularity_select);
   // Compare what the bus carries against what this device would drive
   assign cmp_err = (state_reg.result_drive | state_reg.ctrl.slave_mode) &
                    ((result_bus_in != state_reg.holding_register) |
                     (result_bus_parity_in != state_reg.result_bus_parity));
   // Holding clock is foreign, so only the second sync stage is looked at
   assign hold_edge = state_reg.hold_clk_sync[1] & ~state_reg.hold_clk_last;
   assign access = (avs_read_in | avs_write_in) & ~state_reg.ack;
   assign ctrl_word = {25'h000_0000, state_reg.ctrl};
   assign wmerge = be_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);

   // ************************************************************
   // Next-state logic
   // ************************************************************

   // One process computes the whole next state
   always_comb begin
      state_next = state_reg;
      // Bus answer: one wait cycle, then the request is accepted
      state_next.ack = access;
      // Parity errors are registered so the pins come from flip-flops
      state_next.first_bus_parity_error = perr_a;
      state_next.second_bus_parity_error = perr_b;
      state_next.lockstep_compare_error = cmp_err;
      // Temp register: rising edge takes bus now, the later edge takes staged data
      state_next.temp_stage = {first_operand_bus_in, second_operand_bus_in};
      state_next.temp_stage_valid = temp_register_load_in;
      if (!state_reg.ctrl.temp_load_edge_select) begin
         if (temp_register_load_in) begin
            state_next.temp_register = {first_operand_bus_in, second_operand_bus_in};
         end
      end else if (state_reg.temp_stage_valid) begin
         state_next.temp_register = state_reg.temp_stage;
      end
      // Input latches hold still while in flowthrough
      if (left_input_load_enable_in && !state_reg.ctrl.input_pipeline_select) begin
         state_next.left_input_latch = underflow(left_source,
                                                 state_reg.ctrl.sudden_underflow);
      end
      if (right_input_load_enable_in && !state_reg.ctrl.input_pipeline_select) begin
         state_next.right_input_latch = underflow(right_source,
                                                  state_reg.ctrl.sudden_underflow);
      end
      // Holding register follows its own clock, seen through two flops
      state_next.hold_clk_sync = {state_reg.hold_clk_sync[0], holding_register_clock_in};
      state_next.hold_clk_last = state_reg.hold_clk_sync[1];
      if (hold_edge && !holding_register_write_enable_n_in) begin
         state_next.holding_register = underflow(result_data_in,
                                                 state_reg.ctrl.sudden_underflow);
      end
      state_next.result_bus_parity = parity_gen(state_reg.holding_register,
                                                state_reg.ctrl.parity_granularity_select);
      // A slave in a lockstep pair listens and never drives
      state_next.result_drive = ~result_output_enable_n_in & ~state_reg.ctrl.slave_mode;
      // Sticky status: new events set bits, set wins over a write-one clear
      if (avs_write_in && state_reg.ack && avs_address_in == `FPIC_OFS_STATUS
          && avs_byteenable_in[0]) begin
         state_next.status = state_reg.status & ~avs_writedata_in[`FPIC_ST_W-1:0];
      end
      state_next.status[`FPIC_ST_PERR_A] = state_next.status[`FPIC_ST_PERR_A] | perr_a;
      state_next.status[`FPIC_ST_PERR_B] = state_next.status[`FPIC_ST_PERR_B] | perr_b;
      state_next.status[`FPIC_ST_CMP] = state_next.status[`FPIC_ST_CMP] | cmp_err;
      // Register writes take effect on the accepting edge only
      if (avs_write_in && state_reg.ack) begin
         if (avs_address_in == `FPIC_OFS_CTRL) begin
            state_next.ctrl = fpic_ctrl_type'(wmerge[`FPIC_CTRL_W-1:0]);
         end else if (avs_address_in == `FPIC_OFS_MASK && avs_byteenable_in[0]) begin
            state_next.mask = avs_writedata_in[`FPIC_ST_W-1:0];
         end
      end
      // Read data is fetched in the wait cycle; unmapped reads return zero
      if (avs_read_in && !state_reg.ack) begin
         if (avs_address_in == `FPIC_OFS_CTRL) begin
            state_next.readdata = ctrl_word;
         end else if (avs_address_in == `FPIC_OFS_STATUS) begin
            state_next.readdata = {29'h0000_0000, state_reg.status};
         end else if (avs_address_in == `FPIC_OFS_MASK) begin
            state_next.readdata = {29'h0000_0000, state_reg.mask};
         end else if (avs_address_in == `FPIC_OFS_LEFT) begin
            state_next.readdata = state_reg.left_input_latch;
         end else if (avs_address_in == `FPIC_OFS_RIGHT) begin
            state_next.readdata = state_reg.right_input_latch;
         end else if (avs_address_in == `FPIC_OFS_TEMP_LO) begin
            state_next.readdata = state_reg.temp_register[31:0];
         end else if (avs_address_in == `FPIC_OFS_TEMP_HI) begin
            state_next.readdata = state_reg.temp_register[63:32];
         end else if (avs_address_in == `FPIC_OFS_HOLD) begin
            state_next.readdata = state_reg.holding_register;
         end else begin
            state_next.readdata = 32'h0000_0000;
         end
      end
   end

   // ************************************************************
   // State register
   // ************************************************************

   // Every flop runs on the master clock; the holding clock is only sampled
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
         state_reg.ctrl <= fpic_ctrl_type'(`FPIC_CTRL_RESET);
         state_reg.status <= `FPIC_ST_RESET;
         state_reg.mask <= `FPIC_ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   // Flowthrough bypasses the latches, costing a combinational path to the pins
   assign left_operand_out = state_reg.ctrl.input_pipeline_select ?
                             underflow(left_source, state_reg.ctrl.sudden_underflow) :
                             state_reg.left_input_latch;
   assign right_operand_out = state_reg.ctrl.input_pipeline_select ?
                              underflow(right_source, state_reg.ctrl.sudden_underflow) :
                              state_reg.right_input_latch;
   // Result bus and parity lanes
   assign result_bus_out = state_reg.holding_register;
   assign result_bus_oe_out = state_reg.result_drive;
   assign result_bus_parity_out = state_reg.result_bus_parity;
   assign result_bus_parity_oe_out = state_reg.result_drive;
   // Error pins
   assign first_bus_parity_error_out = state_reg.first_bus_parity_error;
   assign second_bus_parity_error_out = state_reg.second_bus_parity_error;
   assign lockstep_compare_error_out = state_reg.lockstep_compare_error;
   // Bus handshake and interrupt
   assign avs_waitrequest_out = access;
   assign avs_readdata_out = state_reg.readdata;
   assign irq_out = |(state_reg.status & state_reg.mask);

endmodule // fpic_input_ctrl

// ---- verif/fpic_host_model.sv ----
// Host datapath model driving both operand buses with even parity
`timescale 1ns/10ps
module fpic_host_model (
   // Controls from the bench
   input wire logic byte_mode_in,
   input wire logic [31:0] a_in,
   input wire logic [31:0] b_in,
   input wire logic [3:0] flip_a_in,
   input wire logic [3:0] flip_b_in,
   // Bus side
   output logic [31:0] bus_a_out,
   output logic [31:0] bus_b_out,
   output logic [3:0] par_a_out,
   output logic [3:0] par_b_out
);
   // Word mode puts junk on the upper parity lines, which must be ignored
   function automatic logic [3:0] even_par(input logic [31:0] d, input logic bm);
      even_par = bm ? {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} : {~d[3:1], ^d};
   endfunction
   // Flip bits let the bench break parity on purpose
   assign bus_a_out = a_in;
   assign bus_b_out = b_in;
   assign par_a_out = even_par(a_in, byte_mode_in) ^ flip_a_in;
   assign par_b_out = even_par(b_in, byte_mode_in) ^ flip_b_in;
endmodule // fpic_host_model

// ---- verif/fpic_input_ctrl_sva.sv ----
// Concurrent checks on the operand input control ports
`timescale 1ns/10ps
`include "fpic_defines.svh"
module fpic_input_ctrl_sva (
   // Clock, reset and register bus
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [`FPIC_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic avs_waitrequest_out,
   // Operand side
   input wire logic [31:0] first_operand_bus_in,
   input wire logic [31:0] second_operand_bus_in,
   input wire logic [3:0] first_bus_parity_in,
   input wire logic [3:0] second_bus_parity_in,
   input wire logic first_bus_parity_error_out,
   input wire logic second_bus_parity_error_out,
   input wire logic left_input_load_enable_in,
   input wire logic [31:0] left_operand_out,
   input wire logic [31:0] right_operand_out,
   // Holding register and result bus
   input wire logic holding_register_clock_in,
   input wire logic holding_register_write_enable_n_in,
   input wire logic [31:0] result_data_in,
   input wire logic result_output_enable_n_in,
   input wire logic [31:0] result_bus_out,
   input wire logic result_bus_oe_out
);
   logic [`FPIC_CTRL_W-1:0] ctrl_reg;
   logic wr_done;
   assign wr_done = avs_write_in && !avs_waitrequest_out;
   // Shadow of the control register, since mode bits never reach a pin
   always_ff @(posedge clk_in) begin
      if (!rst_n_in)
         ctrl_reg <= `FPIC_CTRL_RESET;
      else if (wr_done && avs_address_in == `FPIC_OFS_CTRL)
         ctrl_reg <= avs_writedata_in[`FPIC_CTRL_W-1:0];
   end
   function automatic logic bad(input logic [31:0] d, input logic [3:0] p, input logic bm);
      bad = bm ? |(p ^ {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]}) : (p[0] ^ ^d);
   endfunction
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_hold_go;
      $rose(holding_register_clock_in) && !holding_register_write_enable_n_in && !ctrl_reg[5];
   endsequence
   a_perr_first: assert property (
      rst_n_in |=> first_bus_parity_error_out ==
      $past(bad(first_operand_bus_in, first_bus_parity_in, ctrl_reg[0])))
      else $error("first bus parity flag wrong");
   a_perr_second: assert property (
      rst_n_in |=> second_bus_parity_error_out ==
      $past(bad(second_operand_bus_in, second_bus_parity_in, ctrl_reg[0])))
      else $error("second bus parity flag wrong");
   a_wait_once: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("wait state count wrong");
   a_left_load: assert property (
      left_input_load_enable_in && ctrl_reg[5:2] == 4'h0 && !avs_write_in
      |=> left_operand_out == $past(first_operand_bus_in))
      else $error("left latch did not load");
   a_left_hold: assert property (
      !left_input_load_enable_in && !ctrl_reg[4] && !avs_write_in |=> $stable(left_operand_out))
      else $error("left latch changed unloaded");
   a_flow_through: assert property (
      ctrl_reg[5:2] == 4'h4 |-> left_operand_out == first_operand_bus_in &&
      right_operand_out == second_operand_bus_in)
      else $error("flowthrough path wrong");
   a_hold_write: assert property (
      s_hold_go |-> ##[1:5] result_bus_out == result_data_in)
      else $error("holding register not written");
   a_hold_guard: assert property (
      holding_register_write_enable_n_in [*5] |-> $stable(result_bus_out))
      else $error("holding register written while disabled");
   a_drive_enable: assert property (
      rst_n_in |=> result_bus_oe_out ==
      (!$past(result_output_enable_n_in) && !$past(ctrl_reg[6])))
      else $error("result bus drive enable wrong");
endmodule // fpic_input_ctrl_sva
bind fpic_input_ctrl fpic_input_ctrl_sva u_sva (.*);

// ---- verif/test_fpic_input_ctrl.sv ----
// Self-checking bench for the operand input control block
`timescale 1ns/10ps
`include "fpic_defines.svh"
module test_fpic_input_ctrl;
   localparam logic [31:0] A1 = 32'h3F80_1111, A2 = 32'h4100_2222;
   localparam logic [31:0] B1 = 32'hC000_3333, B2 = 32'h4200_4444;
   // Rows: byte mode, data on both buses, flips A and B, expected errors A and B
   localparam logic [42:0] ROWS [6] = '{{1'h0, 32'h1234_5678, 4'h0, 4'h0, 2'h0},
      {1'h0, 32'h0000_0001, 4'h1, 4'h0, 2'h2}, {1'h0, 32'hFFFF_0000, 4'hE, 4'h0, 2'h0},
      {1'h1, 32'hA5A5_0F01, 4'h0, 4'h0, 2'h0}, {1'h1, 32'h8000_0001, 4'h8, 4'h1, 2'h3},
      {1'h1, 32'hFFFF_FFFF, 4'h0, 4'h4, 2'h1}};
   logic clk_in, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0, irq_out;
   logic [5:0] avs_address_in = 6'h00;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q, d;
   logic [3:0] avs_byteenable_in = 4'hF, first_bus_parity_in, second_bus_parity_in;
   logic avs_waitrequest_out, first_bus_parity_error_out, second_bus_parity_error_out;
   logic [31:0] first_operand_bus_in, second_operand_bus_in, left_operand_out, right_operand_out;
   logic left_input_load_enable_in = 0, right_input_load_enable_in = 0;
   logic temp_register_load_in = 0, holding_register_clock_in = 0, bm, ea, eb;
   logic holding_register_write_enable_n_in = 1, result_output_enable_n_in = 1, byte_mode = 0;
   logic [31:0] result_data_in = 32'h0, result_bus_in, result_bus_out, a_val = 0, b_val = 0;
   logic result_bus_oe_out, result_bus_parity_oe_out, lockstep_compare_error_out;
   logic [3:0] result_bus_parity_in, result_bus_parity_out, flip_a = 0, flip_b = 0, fa, fb;
   int n_mismatch = 0, comparisons = 0;
   fpic_input_ctrl u_dut (.*);
   fpic_host_model u_host (.byte_mode_in(byte_mode), .a_in(a_val), .b_in(b_val),
      .flip_a_in(flip_a), .flip_b_in(flip_b), .bus_a_out(first_operand_bus_in),
      .bus_b_out(second_operand_bus_in), .par_a_out(first_bus_parity_in),
      .par_b_out(second_bus_parity_in));
   // Undriven result bus shows the inverse so a stale value never matches by luck
   assign result_bus_in = result_bus_oe_out ? result_bus_out : ~result_bus_out;
   assign result_bus_parity_in = result_bus_parity_oe_out ? result_bus_parity_out :
      ~result_bus_parity_out;
   initial begin
      clk_in = 0;
      forever #50 clk_in = ~clk_in;
   end
   task results();
      if (n_mismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon transfer; waits for waitrequest low, only the watchdog ends a hang
   task bus(input logic w, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_write_in <= w;
      avs_read_in <= !w;
      avs_writedata_in <= wd;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'h0) begin
         @(posedge clk_in);
      end
      rd = avs_readdata_out;
      avs_write_in <= 1'h0;
      avs_read_in <= 1'h0;
   endtask
   // Pulse the holding clock, holding data and enable steady around it
   task hold(input logic we_n, input logic [31:0] hd);
      @(posedge clk_in);
      holding_register_write_enable_n_in <= we_n;
      result_data_in <= hd;
      holding_register_clock_in <= 1'h1;
      repeat (4) @(posedge clk_in);
      holding_register_clock_in <= 1'h0;
      repeat (4) @(posedge clk_in);
      holding_register_write_enable_n_in <= 1'h1;
      @(negedge clk_in);
   endtask
   // One-cycle parity failure on the first bus
   task spoil_a();
      @(posedge clk_in);
      flip_a <= 4'h1;
      @(posedge clk_in);
      flip_a <= 4'h0;
      @(negedge clk_in);
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'h1;
      bus(1'h0, `FPIC_OFS_CTRL, 32'h0, q);
      chk(q, 32'h0);
      bus(1'h0, 6'h3C, 32'h0, q);
      chk(q, 32'h0);
      foreach (ROWS[i]) begin
         {bm, d, fa, fb, ea, eb} = ROWS[i];
         bus(1'h1, `FPIC_OFS_CTRL, {31'h0, bm}, q);
         byte_mode <= bm;
         repeat (2) @(posedge clk_in);
         a_val <= d;
         b_val <= d;
         flip_a <= fa;
         flip_b <= fb;
         @(posedge clk_in);
         flip_a <= 4'h0;
         flip_b <= 4'h0;
         @(negedge clk_in);
         chk(first_bus_parity_error_out, ea);
         chk(second_bus_parity_error_out, eb);
      end
      // Interrupt raised, cleared, then masked
      bus(1'h1, `FPIC_OFS_CTRL, 32'h0, q);
      byte_mode <= 1'h0;
      bus(1'h1, `FPIC_OFS_STATUS, 32'h7, q);
      bus(1'h1, `FPIC_OFS_MASK, 32'h1, q);
      spoil_a();
      chk(irq_out, 1'h1);
      bus(1'h1, `FPIC_OFS_STATUS, 32'h1, q);
      @(negedge clk_in);
      chk(irq_out, 1'h0);
      bus(1'h1, `FPIC_OFS_MASK, 32'h0, q);
      spoil_a();
      chk(irq_out, 1'h0);
      bus(1'h0, `FPIC_OFS_STATUS, 32'h0, q);
      chk(q & 32'h1, 32'h1);
      // Clocked loads, each latch on its own enable
      a_val <= A1;
      b_val <= B1;
      left_input_load_enable_in <= 1'h1;
      @(posedge clk_in);
      left_input_load_enable_in <= 1'h0;
      right_input_load_enable_in <= 1'h1;
      a_val <= A2;
      b_val <= B2;
      @(posedge clk_in);
      right_input_load_enable_in <= 1'h0;
      @(negedge clk_in);
      chk(left_operand_out, A1);
      chk(right_operand_out, B2);
      // Temp capture on both edge settings, then every source encoding
      for (int e = 0; e < 2; e++) begin
         bus(1'h1, `FPIC_OFS_CTRL, {30'h0, e[0], 1'h0}, q);
         a_val <= A1;
         b_val <= B1;
         temp_register_load_in <= 1'h1;
         @(posedge clk_in);
         temp_register_load_in <= 1'h0;
         a_val <= A2;
         b_val <= B2;
         for (int s = 0; s < 4; s++) begin
            bus(1'h1, `FPIC_OFS_CTRL, {27'h0, 1'h1, s[1:0], e[0], 1'h0}, q);
            @(negedge clk_in);
            chk(left_operand_out, s[0] ? A1 : A2);
            chk(right_operand_out, (s[0] ^ s[1]) ? B1 : B2);
         end
      end
      // Holding register writes, guard and underflow modes
      bus(1'h1, `FPIC_OFS_CTRL, 32'h0, q);
      hold(1'h0, 32'h0000_1234);
      chk(result_bus_out, 32'h0000_1234);
      hold(1'h1, B1);
      chk(result_bus_out, 32'h0000_1234);
      bus(1'h1, `FPIC_OFS_CTRL, 32'h20, q);
      hold(1'h0, 32'h8000_1234);
      chk(result_bus_out, 32'h8000_0000);
      chk(result_bus_parity_out, 4'h1);
      @(posedge clk_in);
      result_output_enable_n_in <= 1'h0;
      repeat (2) @(negedge clk_in);
      chk(result_bus_oe_out, 1'h1);
      chk(result_bus_parity_oe_out, 1'h1);
      chk(lockstep_compare_error_out, 1'h0);
      // Compare-only mode stops driving, so the undriven bus no longer matches
      bus(1'h1, `FPIC_OFS_CTRL, 32'h40, q);
      repeat (3) @(negedge clk_in);
      chk(result_bus_oe_out, 1'h0);
      chk(lockstep_compare_error_out, 1'h1);
      results();
   end
   // Watchdog against a hung handshake
   initial begin
      #200_000;
      n_mismatch++;
      results();
   end
endmodule // test_fpic_input_ctrl
